// ### ucef_top.sv
// Unit configuration error flag bank with AXI4-Lite register access
`default_nettype none
// Contract
// - A unit number found twice in table checking sets the table duplicate flag.
// - Error-free table generation clears all four table error flags.
// - A special unit error during table generation sets its table flag.
// - The table unconfirmed flag is set while unit detection is unfinished.
// - Two bus units with one unit number set the fatal duplication flag.
// - Two special units with one unit number set the fatal duplication flag.
// - Two basic units with overlapping words set the fatal duplication flag.
// - Two expansion racks with one rack number set the fatal duplication flag.
// - On the high-end variant an interrupt unit beyond slot 4 sets its flag.
// - On the compact variant an interrupt unit beyond slot 2 sets its flag.
// - A bus unit duplicate sets the fatal flag and that unit's bit together.
// - Per-unit word bits 0 to 15 stand for unit numbers 0 to F.
// - A failed bus unit exchange sets the summary flag and the unit bit.
// - A bus unit setting error sets the summary flag and the unit bit.
// - A bus unit unlike the one in the table sets the setting error flag.
// - Any bus unit exchange failure sets the bus unit error flag.
module ucef_top #(
	parameter bit COMPACT_CPU = 1'b0
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [ucef_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	input  wire logic [ucef_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [ucef_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	output var  logic [ucef_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          table_ok,
	input  wire logic                          table_dup_evt,
	input  wire logic                          table_bus_err_evt,
	input  wire logic                          table_special_err_evt,
	input  wire logic                          detect_busy,
	input  wire ucef_pkg::ucef_unit_evt_type   bus_dup_evt,
	input  wire logic                          special_dup_evt,
	input  wire logic                          basic_overlap_evt,
	input  wire logic                          rack_dup_evt,
	input  wire ucef_pkg::ucef_int_unit_type   int_unit,
	input  wire ucef_pkg::ucef_unit_evt_type   bus_xfer_err_evt,
	input  wire ucef_pkg::ucef_unit_evt_type   bus_setting_evt,
	input  wire logic                          flags_clear,
	output var  logic                          irq
);
	// ************************************************************
	// Decoding helpers
	// ************************************************************
	function automatic logic [ucef_pkg::UNIT_COUNT-1:0] unit_bit(
		input ucef_pkg::ucef_unit_evt_type evt
	);
		logic [ucef_pkg::UNIT_COUNT-1:0] v;
		v = '0;
		if (evt.valid) begin
			v[evt.unit] = 1'b1;
		end
		return v;
	endfunction : unit_bit

	// Every register is one aligned word; any other address gets SLVERR
	function automatic logic reg_mapped(
		input logic [ucef_pkg::AXI_ADDR_W-1:0] addr
	);
		logic hit;
		hit = 1'b0;
		if (addr == ucef_pkg::OFS_TABLE_FLAGS) begin
			hit = 1'b1;
		end else if (addr == ucef_pkg::OFS_SYS_FLAGS) begin
			hit = 1'b1;
		end else if (addr == ucef_pkg::OFS_DUP_BITS) begin
			hit = 1'b1;
		end else if (addr == ucef_pkg::OFS_ERR_BITS) begin
			hit = 1'b1;
		end else if (addr == ucef_pkg::OFS_SET_BITS) begin
			hit = 1'b1;
		end else if (addr == ucef_pkg::OFS_IRQ_STATUS) begin
			hit = 1'b1;
		end else if (addr == ucef_pkg::OFS_IRQ_MASK) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : reg_mapped

	localparam logic [3:0] INT_SLOT_MAX = COMPACT_CPU ?
		ucef_pkg::INT_SLOT_MAX_COMPACT : ucef_pkg::INT_SLOT_MAX_HIGH;

	// ************************************************************
	// Error flags
	// ************************************************************
	logic tbl_dup_q;
	logic tbl_bus_q;
	logic tbl_special_q;
	logic tbl_unconf_q;
	logic fatal_dup_q;
	logic int_pos_q;
	logic setting_q;
	logic bus_err_q;
	logic [ucef_pkg::UNIT_COUNT-1:0] dup_bits_q;
	logic [ucef_pkg::UNIT_COUNT-1:0] err_bits_q;
	logic [ucef_pkg::UNIT_COUNT-1:0] set_bits_q;
	logic fatal_set;
	logic int_pos_set;

	assign fatal_set = bus_dup_evt.valid | special_dup_evt
		| basic_overlap_evt | rack_dup_evt;
	assign int_pos_set = int_unit.present
		&& (int_unit.slot > INT_SLOT_MAX);

	// Set wins over the clear in the same cycle, so no event is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tbl_dup_q     <= 1'b0;
			tbl_bus_q     <= 1'b0;
			tbl_special_q <= 1'b0;
			tbl_unconf_q  <= 1'b0;
		end else begin
			if (table_dup_evt) begin
				tbl_dup_q <= 1'b1;
			end else if (table_ok) begin
				tbl_dup_q <= 1'b0;
			end
			if (table_bus_err_evt) begin
				tbl_bus_q <= 1'b1;
			end else if (table_ok) begin
				tbl_bus_q <= 1'b0;
			end
			if (table_special_err_evt) begin
				tbl_special_q <= 1'b1;
			end else if (table_ok) begin
				tbl_special_q <= 1'b0;
			end
			if (detect_busy) begin
				tbl_unconf_q <= 1'b1;
			end else if (table_ok) begin
				tbl_unconf_q <= 1'b0;
			end
		end
	end

	// Summary flags leave only through the CPU's own error clear strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fatal_dup_q <= 1'b0;
			int_pos_q   <= 1'b0;
			setting_q   <= 1'b0;
			bus_err_q   <= 1'b0;
		end else begin
			if (fatal_set) begin
				fatal_dup_q <= 1'b1;
			end else if (flags_clear) begin
				fatal_dup_q <= 1'b0;
			end
			if (int_pos_set) begin
				int_pos_q <= 1'b1;
			end else if (flags_clear) begin
				int_pos_q <= 1'b0;
			end
			if (bus_setting_evt.valid) begin
				setting_q <= 1'b1;
			end else if (flags_clear) begin
				setting_q <= 1'b0;
			end
			if (bus_xfer_err_evt.valid) begin
				bus_err_q <= 1'b1;
			end else if (flags_clear) begin
				bus_err_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dup_bits_q <= ucef_pkg::UNIT_BITS_RESET;
			err_bits_q <= ucef_pkg::UNIT_BITS_RESET;
			set_bits_q <= ucef_pkg::UNIT_BITS_RESET;
		end else if (flags_clear) begin
			dup_bits_q <= unit_bit(bus_dup_evt);
			err_bits_q <= unit_bit(bus_xfer_err_evt);
			set_bits_q <= unit_bit(bus_setting_evt);
		end else begin
			dup_bits_q <= dup_bits_q | unit_bit(bus_dup_evt);
			err_bits_q <= err_bits_q | unit_bit(bus_xfer_err_evt);
			set_bits_q <= set_bits_q | unit_bit(bus_setting_evt);
		end
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	logic [ucef_pkg::IRQ_W-1:0] irq_status_q;
	logic [ucef_pkg::IRQ_W-1:0] irq_mask_q;
	logic [ucef_pkg::IRQ_W-1:0] irq_events;
	logic [ucef_pkg::IRQ_W-1:0] irq_clear;

	always_comb begin
		irq_events = '0;
		irq_events[ucef_pkg::IRQ_TABLE_POS] = table_dup_evt
			| table_bus_err_evt | table_special_err_evt;
		irq_events[ucef_pkg::IRQ_FATAL_POS]   = fatal_set;
		irq_events[ucef_pkg::IRQ_INT_POS]     = int_pos_set;
		irq_events[ucef_pkg::IRQ_BUS_ERR_POS] = bus_xfer_err_evt.valid;
		irq_events[ucef_pkg::IRQ_SETTING_POS] = bus_setting_evt.valid;
	end

	// A new event outweighs a write-one clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_events;
		end
	end

	// Registered, so irq trails its status bit by one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// ************************************************************
	// AXI4-Lite write channel
	// ************************************************************
	logic                            aw_have_q;
	logic                            w_have_q;
	logic [ucef_pkg::AXI_ADDR_W-1:0] waddr_q;
	logic [ucef_pkg::AXI_DATA_W-1:0] wdata_q;
	logic [3:0]                      wstrb_q;
	logic                            wr_fire;

	// Address and data may come in either order; the answer waits for both
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	// Mask and status live in byte lane 0; the other lanes are ignored
	function automatic logic lane0_write(
		input logic [ucef_pkg::AXI_ADDR_W-1:0] target
	);
		return wr_fire && waddr_q == target && wstrb_q[0];
	endfunction : lane0_write

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			waddr_q       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q     <= 1'b1;
			s_axi_awready <= 1'b0;
			waddr_q       <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
		end else if (!aw_have_q && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_q     <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_q      <= '0;
			wstrb_q      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q     <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
		end else if (!w_have_q && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Flag registers answer OKAY to writes but keep their value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ucef_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (reg_mapped(waddr_q)) begin
				s_axi_bresp <= ucef_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= ucef_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_comb begin
		irq_clear = '0;
		if (lane0_write(ucef_pkg::OFS_IRQ_STATUS)) begin
			irq_clear = wdata_q[ucef_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_q <= ucef_pkg::IRQ_MASK_RESET;
		end else if (lane0_write(ucef_pkg::OFS_IRQ_MASK)) begin
			irq_mask_q <= wdata_q[ucef_pkg::IRQ_W-1:0];
		end
	end

	// ************************************************************
	// AXI4-Lite read channel
	// ************************************************************
	logic [ucef_pkg::AXI_DATA_W-1:0] rd_word;
	logic                            rd_hit;

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		if (s_axi_araddr == ucef_pkg::OFS_TABLE_FLAGS) begin
			rd_word[ucef_pkg::TBL_DUP_POS]     = tbl_dup_q;
			rd_word[ucef_pkg::TBL_BUS_POS]     = tbl_bus_q;
			rd_word[ucef_pkg::TBL_SPECIAL_POS] = tbl_special_q;
			rd_word[ucef_pkg::TBL_UNCONF_POS]  = tbl_unconf_q;
		end else if (s_axi_araddr == ucef_pkg::OFS_SYS_FLAGS) begin
			rd_word[ucef_pkg::SYS_FATAL_DUP_POS] = fatal_dup_q;
			rd_word[ucef_pkg::SYS_INT_POS_POS]   = int_pos_q;
			rd_word[ucef_pkg::SYS_SETTING_POS]   = setting_q;
			rd_word[ucef_pkg::SYS_BUS_ERR_POS]   = bus_err_q;
		end else if (s_axi_araddr == ucef_pkg::OFS_DUP_BITS) begin
			rd_word[ucef_pkg::UNIT_COUNT-1:0] = dup_bits_q;
		end else if (s_axi_araddr == ucef_pkg::OFS_ERR_BITS) begin
			rd_word[ucef_pkg::UNIT_COUNT-1:0] = err_bits_q;
		end else if (s_axi_araddr == ucef_pkg::OFS_SET_BITS) begin
			rd_word[ucef_pkg::UNIT_COUNT-1:0] = set_bits_q;
		end else if (s_axi_araddr == ucef_pkg::OFS_IRQ_STATUS) begin
			rd_word[ucef_pkg::IRQ_W-1:0] = irq_status_q;
		end else if (s_axi_araddr == ucef_pkg::OFS_IRQ_MASK) begin
			rd_word[ucef_pkg::IRQ_W-1:0] = irq_mask_q;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Data are captured with the address and stand until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ucef_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? ucef_pkg::RESP_OKAY
				: ucef_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end
endmodule : ucef_top
`default_nettype wire

// ### ucef_pkg.sv
// Constants and carrier types for the unit configuration error flag bank
`default_nettype none
package ucef_pkg;
	// ************************************************************
	// Bus geometry
	// ************************************************************
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam int UNIT_W     = 4;
	localparam int UNIT_COUNT = 16;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [AXI_ADDR_W-1:0] OFS_TABLE_FLAGS = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFS_SYS_FLAGS   = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFS_DUP_BITS    = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFS_ERR_BITS    = 8'h0C;
	localparam logic [AXI_ADDR_W-1:0] OFS_SET_BITS    = 8'h10;
	localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_STATUS  = 8'h14;
	localparam logic [AXI_ADDR_W-1:0] OFS_IRQ_MASK    = 8'h18;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int TBL_DUP_POS     = 3;
	localparam int TBL_BUS_POS     = 4;
	localparam int TBL_SPECIAL_POS = 7;
	localparam int TBL_UNCONF_POS  = 9;
	localparam int SYS_FATAL_DUP_POS = 0;
	localparam int SYS_INT_POS_POS   = 1;
	localparam int SYS_SETTING_POS   = 2;
	localparam int SYS_BUS_ERR_POS   = 3;
	localparam int IRQ_W           = 5;
	localparam int IRQ_TABLE_POS   = 0;
	localparam int IRQ_FATAL_POS   = 1;
	localparam int IRQ_INT_POS     = 2;
	localparam int IRQ_BUS_ERR_POS = 3;
	localparam int IRQ_SETTING_POS = 4;

	// ************************************************************
	// Reset values and slot limits
	// ************************************************************
	localparam logic [IRQ_W-1:0]      IRQ_MASK_RESET  = 5'h00;
	localparam logic [UNIT_COUNT-1:0] UNIT_BITS_RESET = 16'h0000;
	localparam logic [3:0] INT_SLOT_MAX_HIGH    = 4'h4;
	localparam logic [3:0] INT_SLOT_MAX_COMPACT = 4'h2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic              valid;
		logic [UNIT_W-1:0] unit;
	} ucef_unit_evt_type;

	typedef struct packed {
		logic       present;
		logic [3:0] slot;
	} ucef_int_unit_type;
endpackage : ucef_pkg
`default_nettype wire

// ### ucef_assertions.sv
// Port-level checker for the unit configuration error flag bank
`default_nettype none
module ucef_assertions #(
	parameter bit COMPACT_CPU = 1'h0
) (
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic [7:0]                  s_axi_awaddr,
	input wire logic                        s_axi_awvalid,
	input wire logic                        s_axi_awready,
	input wire logic [31:0]                 s_axi_wdata,
	input wire logic [3:0]                  s_axi_wstrb,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic [1:0]                  s_axi_bresp,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_bready,
	input wire logic [7:0]                  s_axi_araddr,
	input wire logic                        s_axi_arvalid,
	input wire logic                        s_axi_arready,
	input wire logic [1:0]                  s_axi_rresp,
	input wire logic                        s_axi_rvalid,
	input wire logic                        s_axi_rready,
	input wire logic                        table_dup_evt,
	input wire logic                        table_bus_err_evt,
	input wire logic                        table_special_err_evt,
	input wire ucef_pkg::ucef_unit_evt_type bus_dup_evt,
	input wire logic                        special_dup_evt,
	input wire logic                        basic_overlap_evt,
	input wire logic                        rack_dup_evt,
	input wire ucef_pkg::ucef_int_unit_type int_unit,
	input wire ucef_pkg::ucef_unit_evt_type bus_xfer_err_evt,
	input wire ucef_pkg::ucef_unit_evt_type bus_setting_evt,
	input wire logic                        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] mask_q;
	logic [3:0] slot_max;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	assign slot_max = COMPACT_CPU ? ucef_pkg::INT_SLOT_MAX_COMPACT
		: ucef_pkg::INT_SLOT_MAX_HIGH;
	// Shadow of the mask, updated one edge early; irq checks allow for it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			mask_q <= 5'h00;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid
			&& s_axi_wready && s_axi_wstrb[0]
			&& s_axi_awaddr == ucef_pkg::OFS_IRQ_MASK)
			mask_q <= s_axi_wdata[4:0];
	end
	sequence aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence irq_soon;
		##[1:2] irq;
	endsequence
	property irq_follows(cause, m);
		cause && m |-> irq_soon;
	endproperty
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	chk_rresp_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rresp))
		else $error("read response dropped before rready");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read data late");
	chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > ucef_pkg::OFS_IRQ_MASK
		|=> s_axi_rresp == ucef_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	chk_flag_write_ok: assert property (
		aw_w_taken ##0 (s_axi_awaddr <= ucef_pkg::OFS_SET_BITS
		&& s_axi_awaddr[1:0] == 2'h0)
		|-> ##2 (s_axi_bvalid && s_axi_bresp == ucef_pkg::RESP_OKAY))
		else $error("flag write not answered OKAY");
	chk_irq_table: assert property (irq_follows(table_dup_evt
		|| table_bus_err_evt || table_special_err_evt, mask_q[0]))
		else $error("table event raised no interrupt");
	chk_irq_fatal: assert property (irq_follows(bus_dup_evt.valid
		|| special_dup_evt || basic_overlap_evt || rack_dup_evt,
		mask_q[1]))
		else $error("duplication raised no interrupt");
	chk_irq_position: assert property (irq_follows(
		int_unit.present && int_unit.slot > slot_max, mask_q[2]))
		else $error("misplaced interrupt unit raised no interrupt");
	chk_irq_exchange: assert property (
		irq_follows(bus_xfer_err_evt.valid, mask_q[3]))
		else $error("exchange failure raised no interrupt");
	chk_irq_setting: assert property (
		irq_follows(bus_setting_evt.valid, mask_q[4]))
		else $error("setting error raised no interrupt");
endmodule : ucef_assertions
`default_nettype wire

// ### ucef_units_model.sv
// Behavioural model of the expansion units that report configuration events
`default_nettype none
module ucef_units_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [9:0] fire,
	input  wire logic [3:0] unit,
	output var  logic [9:0] evt_q,
	output var  logic [3:0] unit_q
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			evt_q <= 10'h000;
		else
			evt_q <= fire;
	end
	// Unit number means nothing without a pulse; it toggles to expose misuse
	always_ff @(posedge aclk) begin
		if (!aresetn)
			unit_q <= 4'hA;
		else if (fire != 10'h000)
			unit_q <= unit;
		else
			unit_q <= ~unit_q;
	end
endmodule : ucef_units_model
`default_nettype wire

// ### ucef_tb.sv
// Self-checking testbench for the unit configuration error flag bank
`default_nettype none
`define CHECK(got, want) \
	begin \
		checks++; \
		if ((got) !== (want)) begin \
			fails++; \
			$display("ERROR at %0t: got %h want %h", $time, got, want); \
		end \
	end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam bit COMPACT_CPU = 1'h0;
	logic aclk = 1'h0, aresetn = 1'h0, detect_busy = 1'h0, flags_clear = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, m;
	logic [3:0] s_axi_wstrb = 4'hF, unit = 4'h0, uq, u;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [9:0] fire = 10'h000, evt;
	logic [4:0] pos [3] = '{5'h0F, 5'h14, 5'h15};
	ucef_pkg::ucef_int_unit_type int_unit = '0;
	int fails = 0, checks = 0;
	ucef_units_model ucef_units_model_inst (.aclk(aclk), .aresetn(aresetn),
		.fire(fire), .unit(unit), .evt_q(evt), .unit_q(uq));
	ucef_top #(.COMPACT_CPU(COMPACT_CPU)) ucef_top_inst (.*,
		.table_ok(evt[0]), .table_dup_evt(evt[1]),
		.table_bus_err_evt(evt[2]), .table_special_err_evt(evt[3]),
		.bus_dup_evt({evt[4], uq}), .special_dup_evt(evt[5]),
		.basic_overlap_evt(evt[6]), .rack_dup_evt(evt[7]),
		.bus_xfer_err_evt({evt[8], uq}), .bus_setting_evt({evt[9], uq}));
	always #12.5 aclk = ~aclk;
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid || ++n > 50) break;
		end
		if (n > 50) fails++;
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid || ++n > 50) break;
		end
		if (n > 50) fails++;
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rdreg
	// Event k of the model: 0 tables good, 1..3 table faults, 4..7
	// duplications, 8 exchange failure, 9 setting mismatch
	task automatic pulse(input int k, input logic [3:0] uu);
		@(posedge aclk);
		fire <= 10'h001 << k;
		unit <= uu;
		@(posedge aclk);
		fire <= 10'h000;
		repeat (3) @(posedge aclk);
	endtask : pulse
	task automatic clear_all;
		@(posedge aclk);
		flags_clear <= 1'h1;
		@(posedge aclk);
		flags_clear <= 1'h0;
		pulse(0, 4'h0);
		wr(ucef_pkg::OFS_IRQ_STATUS, 32'h1F);
		repeat (2) @(posedge aclk);
	endtask : clear_all
	function automatic logic [31:0] expect_reg(input int k, input int r,
		input logic [3:0] uu);
		case (r)
		0: return k == 1 ? 32'h8 : k == 2 ? 32'h10 : k == 3 ? 32'h80 : 32'h0;
		1: return k inside {[4:7]} ? 32'h1 : k == 8 ? 32'h8
			: k == 9 ? 32'h4 : 32'h0;
		2: return k == 4 ? 32'h1 << uu : 32'h0;
		3: return k == 8 ? 32'h1 << uu : 32'h0;
		4: return k == 9 ? 32'h1 << uu : 32'h0;
		default: return k < 4 ? 32'h1 : k < 8 ? 32'h2 : k == 8 ? 32'h8 : 32'h10;
		endcase
	endfunction : expect_reg
	task automatic give_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial begin
		#500000;
		fails++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'hBD0BA4CF));
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		for (int r = 0; r < 7; r++) begin
			rdreg(8'(4 * r));
			`CHECK(rd, 32'h0)
			if (r > 4) continue;
			wr(8'(4 * r), 32'hFFFFFFFF);
			`CHECK(resp, ucef_pkg::RESP_OKAY)
			rdreg(8'(4 * r));
			`CHECK(rd, 32'h0)
		end
		wr(8'h1C, 32'h1F);
		`CHECK(resp, ucef_pkg::RESP_SLVERR)
		rdreg(8'h1C);
		`CHECK(resp, ucef_pkg::RESP_SLVERR)
		m = $urandom;
		wr(ucef_pkg::OFS_IRQ_MASK, m);
		rdreg(ucef_pkg::OFS_IRQ_MASK);
		`CHECK(rd, {27'h0, m[4:0]})
		// Masked exchange failure stays silent until its mask bit opens
		wr(ucef_pkg::OFS_IRQ_MASK, 32'h17);
		pulse(8, 4'h3);
		`CHECK(irq, 1'h0)
		wr(ucef_pkg::OFS_IRQ_MASK, 32'h1F);
		repeat (2) @(posedge aclk);
		`CHECK(irq, 1'h1)
		clear_all;
		for (int k = 1; k < 10; k++) begin
			for (int j = 0; j < 2; j++) begin
				u = j ? 4'($urandom_range(15, 0)) : (k % 2 ? 4'h0 : 4'hF);
				pulse(k, u);
				`CHECK(irq, 1'h1)
				for (int r = 0; r < 6; r++) begin
					rdreg(8'(4 * r));
					`CHECK(rd, expect_reg(k, r, u))
				end
				clear_all;
				`CHECK(irq, 1'h0)
			end
		end
		detect_busy <= 1'h1;
		pulse(1, 4'h0);
		rdreg(ucef_pkg::OFS_TABLE_FLAGS);
		`CHECK(rd, 32'h208)
		detect_busy <= 1'h0;
		pulse(0, 4'h0);
		rdreg(ucef_pkg::OFS_TABLE_FLAGS);
		`CHECK(rd, 32'h0)
		clear_all;
		for (int i = 0; i < 3; i++) begin
			int_unit <= pos[i];
			repeat (3) @(posedge aclk);
			rdreg(ucef_pkg::OFS_SYS_FLAGS);
			`CHECK(rd, (i == 2) ? 32'h2 : 32'h0)
		end
		int_unit <= '0;
		clear_all;
		rdreg(ucef_pkg::OFS_SYS_FLAGS);
		`CHECK(rd, 32'h0)
		give_verdict;
	end
endmodule : tb
bind ucef_top ucef_assertions #(.COMPACT_CPU(COMPACT_CPU))
	ucef_assertions_inst (.*);
`default_nettype wire
